// File: rtl/hwf_pkg.sv
// package for the high-voltage wake input filter
package hwf_pkg;
  localparam int          CLK_MHZ              = 125;
  localparam int          FILT_SHORT_US        = 16;
  localparam int          FILT_LONG_US         = 64;
  localparam int          FILT_SHORT_CYC       = FILT_SHORT_US * CLK_MHZ;
  localparam int          FILT_LONG_CYC        = FILT_LONG_US * CLK_MHZ;
  localparam int          FILT_CNT_W           = 14;
  localparam logic [1:0]  PULL_RESET           = 2'h0;
  localparam logic        FILT_SEL_RESET       = 1'h0;
  localparam logic        WAKE_EN_RESET        = 1'h0;

  typedef enum logic [1:0] {
    HWF_PULL_NONE = 2'b00,
    HWF_PULL_DOWN = 2'b01,
    HWF_PULL_UP   = 2'b10,
    HWF_PULL_AUTO = 2'b11
  } hwf_pull_type;

  typedef enum logic [2:0] {
    HWF_MODE_INIT     = 3'b000,
    HWF_MODE_NORMAL   = 3'b001,
    HWF_MODE_STOP     = 3'b010,
    HWF_MODE_SLEEP    = 3'b011,
    HWF_MODE_FAILSAFE = 3'b100
  } hwf_mode_type;

  typedef struct packed {
    logic         wake_enable;
    logic         wake_filter_select;
    logic         pull_select_upper;
    logic         pull_select_lower;
  } hwf_ctrl_type;

  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
  } hwf_pull_en_type;
endpackage : hwf_pkg

// File: rtl/hwf_filter.sv
// restartable glitch filter counter for the synchronized comparator level
`timescale 1ns/10ps
`default_nettype none
module hwf_filter #(
  parameter int SHORT_CYC = hwf_pkg::FILT_SHORT_CYC,
  parameter int LONG_CYC  = hwf_pkg::FILT_LONG_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic level_in,
  input  wire logic long_sel_in,
  output logic      stable_level_out,
  output logic      edge_out
);
  import hwf_pkg::*;
  logic [FILT_CNT_W-1:0] cnt_r;
  logic                  last_r;
  logic                  stable_r;
  logic                  edge_r;
  wire  [FILT_CNT_W-1:0] limit = long_sel_in ? FILT_CNT_W'(LONG_CYC - 1) : FILT_CNT_W'(SHORT_CYC - 1);
  wire                   changed = level_in != last_r;
  wire                   done = (cnt_r >= limit) && (last_r != stable_r);

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cnt_r    <= '0;
      last_r   <= 1'b0;
      stable_r <= 1'b0;
      edge_r   <= 1'b0;
    end else begin
      last_r <= level_in;
      // a crossing restarts the count so shorter pulses never qualify
      if (changed) cnt_r <= '0; // see RULE_03 see RULE_12
      else if (cnt_r < limit) cnt_r <= cnt_r + 1'b1;
      if (!changed && done) stable_r <= last_r; // see RULE_03
      edge_r <= !changed && done; // both directions count, see RULE_01
    end
  end
  assign stable_level_out = stable_r;
  assign edge_out         = edge_r;

  chk_glitch_discard: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    changed |=> !edge_r) else $error("edge right after crossing"); // see RULE_03
endmodule : hwf_filter
`default_nettype wire

// File: rtl/hwf_wake_input.sv
// top of the high-voltage wake input: sync, filter, pulls, status and wake signalling
//
// Contract
// RULE_01: wake pin is edge sensitive; both rising and falling transitions signal.
// RULE_02: recognized transition raises interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe.
// RULE_03: each crossing restarts filter; only input stable for full time is recognized.
// RULE_04: a configuration bit enables or disables the pin's wake capability.
// RULE_05: recognized wake event sets a status bit readable at any time.
// RULE_06: level status shows the pin level in Normal, Stop or Init mode.
// RULE_07: pull field 00 none, 01 pull-down, 10 pull-up, 11 automatic.
// RULE_08: automatic mode enables pull-up on high level, pull-down on low level.
// RULE_09: filter select chooses 16 us or 64 us filter time.
// RULE_10: Init to Normal with pin already high sets status and raises interrupt.
// RULE_11: wake status stays set until software clears it.
// RULE_12: filter is a counter reloaded on each change, flags at selected count.
`timescale 1ns/10ps
`default_nettype none
module hwf_wake_input #(
  parameter int SHORT_CYC = hwf_pkg::FILT_SHORT_CYC,
  parameter int LONG_CYC  = hwf_pkg::FILT_LONG_CYC
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     resetn_in,
  input  wire logic                     wake_pin_in,
  input  wire hwf_pkg::hwf_ctrl_type    wake_input_control_in,
  input  wire hwf_pkg::hwf_mode_type    mode_in,
  input  wire logic                     status_clear_in,
  output logic                          wake_event_status_out,
  output logic                          wake_pin_level_status_out,
  output hwf_pkg::hwf_pull_en_type      pull_en_out,
  output logic                          irq_pulse_out,
  output logic                          wake_request_out
);
  import hwf_pkg::*;
  logic          sync1_r;
  logic          sync2_r;
  logic          stable_level;
  logic          edge_hit;
  logic          status_r;
  logic          level_r;
  logic          irq_r;
  logic          wake_r;
  hwf_pull_en_type pull_r;
  hwf_mode_type  mode_prev_r;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= wake_pin_in;
      sync2_r <= sync1_r;
    end
  end

  hwf_filter #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_filter (
    .clk_sys_in       (clk_sys_in),
    .resetn_in        (resetn_in),
    .level_in         (sync2_r),
    .long_sel_in      (wake_input_control_in.wake_filter_select), // see RULE_09
    .stable_level_out (stable_level),
    .edge_out         (edge_hit)
  );

  wire enabled     = wake_input_control_in.wake_enable; // see RULE_04

  // mode groups are decoded once here and reused by the pulse routing and the checks
  function automatic logic mode_is_active(input hwf_mode_type m);
    return (m == HWF_MODE_NORMAL) || (m == HWF_MODE_STOP);
  endfunction : mode_is_active

  function automatic logic mode_is_low_power(input hwf_mode_type m);
    return (m == HWF_MODE_SLEEP) || (m == HWF_MODE_FAILSAFE);
  endfunction : mode_is_low_power

  // init shows the level too, so software can inspect the pin before leaving init
  function automatic logic mode_shows_level(input hwf_mode_type m);
    return mode_is_active(m) || (m == HWF_MODE_INIT);
  endfunction : mode_shows_level

  wire active_mode = mode_is_active(mode_in);
  wire low_pwr     = mode_is_low_power(mode_in);
  wire level_vis   = mode_shows_level(mode_in);
  wire init_to_nrm = (mode_prev_r == HWF_MODE_INIT) && (mode_in == HWF_MODE_NORMAL)
                     && stable_level && enabled; // see RULE_10
  wire event_hit   = (edge_hit && enabled) || init_to_nrm; // see RULE_01 see RULE_04
  wire [1:0] pull_sel = {wake_input_control_in.pull_select_upper, wake_input_control_in.pull_select_lower};
  wire auto_sel    = pull_sel == HWF_PULL_AUTO;
  // auto mode follows the filtered level so a glitch does not flip the source
  wire pu_nxt      = (pull_sel == HWF_PULL_UP) || (auto_sel && stable_level); // see RULE_07 see RULE_08
  wire pd_nxt      = (pull_sel == HWF_PULL_DOWN) || (auto_sel && !stable_level); // see RULE_07 see RULE_08

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      status_r    <= 1'b0;
      level_r     <= 1'b0;
      irq_r       <= 1'b0;
      wake_r      <= 1'b0;
      pull_r      <= '0;
      mode_prev_r <= HWF_MODE_INIT;
    end else begin
      mode_prev_r <= mode_in;
      // set wins over a clear in the same cycle
      if (event_hit) status_r <= 1'b1; // see RULE_05
      else if (status_clear_in) status_r <= 1'b0; // see RULE_11
      if (level_vis) level_r <= sync2_r; // see RULE_06
      irq_r  <= event_hit && active_mode; // see RULE_02
      wake_r <= event_hit && low_pwr; // see RULE_02
      pull_r.pull_up_en   <= pu_nxt;
      pull_r.pull_down_en <= pd_nxt;
    end
  end

  assign wake_event_status_out     = status_r;
  assign wake_pin_level_status_out = level_r;
  assign pull_en_out               = pull_r;
  assign irq_pulse_out             = irq_r;
  assign wake_request_out          = wake_r;

  sequence s_event_active;
    event_hit && active_mode;
  endsequence

  chk_status_sets: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    event_hit |=> status_r) else $error("status not set"); // see RULE_05
  chk_status_holds: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    status_r && !status_clear_in |=> status_r) else $error("status dropped"); // see RULE_11
  chk_irq_active: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_event_active |=> irq_r && !wake_r) else $error("no irq in active mode"); // see RULE_02
  chk_wake_lowpwr: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    event_hit && low_pwr |=> wake_r && !irq_r) else $error("no wake in low power"); // see RULE_02
  chk_disabled_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !enabled |=> !irq_r && !wake_r) else $error("event while disabled"); // see RULE_04
  chk_pull_exclusive: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !(pull_r.pull_up_en && pull_r.pull_down_en)) else $error("both pulls on"); // see RULE_07
  chk_auto_pull: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    auto_sel && stable_level |=> pull_r.pull_up_en) else $error("auto pull wrong"); // see RULE_08
  chk_level_track: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    level_vis |=> level_r == $past(sync2_r)) else $error("level status stale"); // see RULE_06
  chk_init_normal: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    init_to_nrm |=> status_r && irq_r) else $error("init to normal missed"); // see RULE_10

  // leaving init with the pin already high is a two-step behaviour
  sequence s_init_exit;
    (mode_in == HWF_MODE_INIT) ##1 ((mode_in == HWF_MODE_NORMAL) && stable_level && enabled);
  endsequence

  sequence s_clear_alone;
    status_clear_in && !event_hit;
  endsequence

  sequence s_fresh_cross;
    $changed(sync2_r);
  endsequence

  chk_init_exit_irq: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_10
    s_init_exit |=> irq_r && status_r)
    else $error("init exit without irq");

  chk_clear_works: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_11
    s_clear_alone |=> !status_r)
    else $error("status not cleared");

  chk_set_wins: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_05
    event_hit && status_clear_in |=> status_r)
    else $error("clear beat a new event");

  // init only latches the status, the pulse would reach a host still in reset
  chk_init_no_pulse: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_02
    event_hit && (mode_in == HWF_MODE_INIT) |=> !irq_r && !wake_r)
    else $error("pulse in init mode");

  chk_irq_only_active: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_02
    irq_r |-> $past(active_mode))
    else $error("irq outside active modes");

  chk_wake_only_lowpwr: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_02
    wake_r |-> $past(low_pwr))
    else $error("wake outside low power modes");

  chk_pulse_cause: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_05
    irq_r || wake_r |-> $past(event_hit))
    else $error("pulse without event");

  chk_level_frozen: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_06
    !level_vis |=> $stable(level_r))
    else $error("level status moved in low power");

  chk_pull_none: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_07
    (pull_sel == HWF_PULL_NONE) |=> (pull_r == '0))
    else $error("source on with none selected");

  chk_pull_up_fixed: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_07
    (pull_sel == HWF_PULL_UP) |=> pull_r.pull_up_en && !pull_r.pull_down_en)
    else $error("pull-up selection ignored");

  chk_pull_down_fixed: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_07
    (pull_sel == HWF_PULL_DOWN) |=> pull_r.pull_down_en && !pull_r.pull_up_en)
    else $error("pull-down selection ignored");

  chk_auto_pull_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_08
    auto_sel && !stable_level |=> pull_r.pull_down_en)
    else $error("auto pull-down missing");

  // a flip of the filtered level in either direction must come with an edge
  chk_edge_both: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_01
    $changed(stable_level) |-> edge_hit)
    else $error("level flip without edge");

  chk_filter_restart: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_03
    s_fresh_cross |=> !edge_hit)
    else $error("edge right after a crossing");
endmodule : hwf_wake_input
`default_nettype wire

// File: test/hwf_wake_switch.sv
// behavioural wake switch or signal line feeding the wake comparator
`timescale 1ns/10ps
`default_nettype none
module hwf_wake_switch (
  input  wire logic                     clk_sys_in,
  input  wire logic                     drive_en_in,
  input  wire logic                     drive_level_in,
  input  wire hwf_pkg::hwf_pull_en_type pull_en_in,
  output logic                          pin_out
);
  import hwf_pkg::*;
  logic float_r = 1'b0;
  // an open line with no source wanders, so it must never look stable to the filter
  always @(posedge clk_sys_in) float_r <= ~float_r;
  always_comb begin
    if (drive_en_in) pin_out = drive_level_in;
    else if (pull_en_in.pull_up_en) pin_out = 1'b1;
    else if (pull_en_in.pull_down_en) pin_out = 1'b0;
    else pin_out = float_r;
  end
endmodule : hwf_wake_switch
`default_nettype wire

// File: test/hwf_wake_input_tb.sv
// self-checking testbench for the wake input filter
`timescale 1ns/10ps
`default_nettype none
module hwf_wake_input_tb;
  import hwf_pkg::*;
  logic            clk_sys, resetn, clr, drv_en, drv_lvl, pin, st, lvl, irq, wk;
  hwf_ctrl_type    ctl;
  hwf_mode_type    mode;
  hwf_pull_en_type pen;
  int              failures, n_tests, n_irq, n_wk;
  hwf_wake_input #(.SHORT_CYC(4), .LONG_CYC(16)) i_hwf_wake_input (.clk_sys_in(clk_sys), .resetn_in(resetn),
    .wake_pin_in(pin), .wake_input_control_in(ctl), .mode_in(mode), .status_clear_in(clr),
    .wake_event_status_out(st), .wake_pin_level_status_out(lvl), .pull_en_out(pen),
    .irq_pulse_out(irq), .wake_request_out(wk));
  hwf_wake_switch i_hwf_wake_switch (.clk_sys_in(clk_sys), .drive_en_in(drv_en), .drive_level_in(drv_lvl),
    .pull_en_in(pen), .pin_out(pin));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (irq === 1'b1) n_irq++;
    if (wk === 1'b1) n_wk++;
  end
  task automatic cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask : cyc
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ev(input string nm, input int ei, input int ew);
    chk({nm, " irq"}, ei[1:0], n_irq[1:0]);
    chk({nm, " wake"}, ew[1:0], n_wk[1:0]);
    n_irq = 0;
    n_wk = 0;
  endtask : ev
  task automatic pin_to(input logic v, input int n); drv_lvl = v; cyc(n); endtask : pin_to
  task automatic clear_st; clr = 1'b1; cyc(1); clr = 1'b0; cyc(1); endtask : clear_st
  task automatic t_edges;
    pin_to(1, 30); ev("rise", 1, 0);
    chk("status set", 1, st);
    chk("level high", 1, lvl);
    pin_to(1, 50); chk("status sticky", 1, st);
    clear_st; cyc(1); chk("status cleared", 0, st);
    pin_to(0, 30); ev("fall", 1, 0);
    chk("level low", 0, lvl);
    clear_st;
    $display("edges test done");
  endtask : t_edges
  task automatic t_glitch;
    pin_to(1, 2); pin_to(0, 30); ev("short glitch", 0, 0);
    pin_to(1, 3); pin_to(0, 1); pin_to(1, 30); ev("restart", 1, 0);
    ctl.wake_filter_select = 1'b1;
    pin_to(0, 10); pin_to(1, 40); ev("long glitch", 0, 0);
    pin_to(0, 40); ev("long event", 1, 0);
    ctl.wake_filter_select = 1'b0;
    clear_st;
    $display("glitch test done");
  endtask : t_glitch
  task automatic t_modes;
    mode = HWF_MODE_SLEEP; pin_to(1, 30); ev("sleep", 0, 1);
    chk("sleep level held", 0, lvl);
    mode = HWF_MODE_FAILSAFE; pin_to(0, 30); ev("failsafe", 0, 1);
    mode = HWF_MODE_STOP; pin_to(1, 30); ev("stop", 1, 0);
    clear_st; ctl.wake_enable = 1'b0;
    pin_to(0, 30); ev("disabled", 0, 0);
    chk("disabled status", 0, st);
    ctl.wake_enable = 1'b1; mode = HWF_MODE_NORMAL;
    $display("modes test done");
  endtask : t_modes
  task automatic t_pulls;
    for (int p = 0; p < 4; p++) begin
      {ctl.pull_select_upper, ctl.pull_select_lower} = p[1:0];
      cyc(2); chk("pull enables", (p == 0) ? 2'h0 : (p == 2) ? 2'h2 : 2'h1, pen);
    end
    pin_to(1, 30); ev("auto rise", 1, 0); chk("auto pull up", 2'h2, pen);
    drv_en = 1'b0; cyc(30); ev("auto hold", 0, 0); drv_en = 1'b1;
    $display("pulls test done");
  endtask : t_pulls
  task automatic t_init;
    mode = HWF_MODE_INIT; clear_st; cyc(3); chk("init status", 0, st);
    mode = HWF_MODE_NORMAL; cyc(6); ev("init to normal", 1, 0);
    chk("init to normal status", 1, st);
    $display("init test done");
  endtask : t_init
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    #40000;
    failures++;
    end_of_test;
  end
  initial begin
    failures = 0; n_tests = 0; n_irq = 0; n_wk = 0;
    resetn = 1'b0; clr = 1'b0; drv_en = 1'b1; drv_lvl = 1'b0;
    ctl = '{1'b1, 1'b0, 1'b0, 1'b1}; mode = HWF_MODE_NORMAL;
    cyc(2); resetn = 1'b1; cyc(30); ev("after reset", 0, 0);
    t_edges; t_glitch; t_modes; t_pulls; t_init;
    end_of_test;
  end
endmodule : hwf_wake_input_tb
`default_nettype wire
